// [ccsc_avmm_slave.sv]
// Avalon-MM slave front end: one wait state, then read data and write strobe
// assumes the master holds its request until it sees waitrequest low
`timescale 1ns/1ps
`default_nettype none
`include "ccsc_defs.svh"
module ccsc_avmm_slave (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    input  wire logic [7:0]  mode_q,
    input  wire logic [7:0]  sys_q,
    input  wire logic [7:0]  run_q,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             wr_mode,
    output logic             wr_sys,
    output logic             wr_run,
    output logic [7:0]       wdata
);
    ccsc_pkg::ccsc_bus_st_t st;
    ccsc_pkg::ccsc_bus_st_t next_st;
    logic                   wr_go;
    logic [2:0]             sel;

    function automatic logic [2:0] ccsc_sel(input logic [3:0] a);
        ccsc_sel = {a == `CCSC_ADDR_RUN, a == `CCSC_ADDR_SYS, a == `CCSC_ADDR_MODE};
    endfunction

    assign sel = ccsc_sel(address);

    always_comb begin
        next_st = st;
        if (st.wait_q && (read || write)) begin
            next_st.wait_q = 1'b0;
            case (sel)
                3'b001: next_st.rdata = mode_q;
                3'b010: next_st.rdata = sys_q;
                3'b100: next_st.rdata = run_q;
                default: next_st.rdata = 8'h00;
            endcase
        end else begin
            next_st.wait_q = 1'b1;
        end
    end

    // writes land at the edge where waitrequest is seen low
    assign wr_go   = write && !st.wait_q && byteenable[0];
    assign wr_mode = wr_go && sel[0];
    assign wr_sys  = wr_go && sel[1];
    assign wr_run  = wr_go && sel[2];
    assign wdata   = writedata[7:0];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '{wait_q: 1'b1, rdata: 8'h00};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign readdata    = {24'h000000, st.rdata};
    assign waitrequest = st.wait_q;
endmodule
`default_nettype wire

// [ccsc_defs.svh]
// offsets, field positions, reset values and timing counts of the clock source control
// assumes a 200 MHz core clock and byte addresses on an Avalon-MM slave
`ifndef CCSC_DEFS_SVH
`define CCSC_DEFS_SVH
`define CCSC_ADDR_MODE    4'h0
`define CCSC_ADDR_SYS     4'h4
`define CCSC_ADDR_RUN     4'h8
`define CCSC_MODE_EXTCLK  7
`define CCSC_MODE_MAINOSC 6
`define CCSC_MODE_SUBEN   4
`define CCSC_MODE_DRVHI   2
`define CCSC_MODE_DRVLO   1
`define CCSC_MODE_GAIN    0
`define CCSC_MODE_WMASK   8'hd7
`define CCSC_MODE_RESET   8'h00
`define CCSC_SYS_CLS      7
`define CCSC_SYS_CSS      6
`define CCSC_SYS_MCS      5
`define CCSC_SYS_MCM      4
`define CCSC_SYS_FIX      3
`define CCSC_SYS_RESET    8'h09
`define CCSC_RUN_MSTOP    7
`define CCSC_RUN_SUB_CRYSTAL_STOP   6
`define CCSC_RUN_SETTLED  1
`define CCSC_RUN_INTERNAL_FAST_OSC_STOP  0
`define CCSC_RUN_RESET    8'hc0
`define CCSC_DIV_MAX      3'h5
`define CCSC_SUB_SHIFT    3'h1
`define CCSC_CLK_MHZ      200
`define CCSC_SETTLE_NS    10000
`define CCSC_SETTLE_CYC   ((`CCSC_SETTLE_NS * `CCSC_CLK_MHZ + 999) / 1000)
`endif

// [ccsc_pkg.sv]
// types of the clock source control: source codes and state records
// assumes ccsc_defs.svh for numbers
package ccsc_pkg;
    typedef enum logic [2:0] {
        CCSC_SRC_FAST = 3'b001,
        CCSC_SRC_MAIN = 3'b010,
        CCSC_SRC_SUB  = 3'b100
    } ccsc_src_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic       pulse;
    } ccsc_div_st_t;

    typedef struct packed {
        logic       wait_q;
        logic [7:0] rdata;
    } ccsc_bus_st_t;

    typedef struct packed {
        logic [7:0] mode;
        logic       mode_done;
        logic       subclock_cpu_select;
        logic       mcm;
        logic [2:0] div;
        logic       mstop;
        logic       sub_crystal_stop;
        logic       internal_fast_osc_stop;
        ccsc_src_t  src;
        logic       stop;
        logic [10:0] settle_cnt;
        logic       settled;
        logic       restart;
        logic       cpu_clk_en;
        logic       periph_clk_en;
        logic       wdt_clk_en;
        logic       fast_run;
        logic       main_run;
        logic       sub_run;
        logic       low_run;
        logic       port_mode;
        logic       ana_ok;
    } ccsc_top_st_t;
endpackage

// [ccsc_tb_top.sv]
// self-checking bench of the clock source control: register bus, dividers, source switch, stop mode
// assumes ccsc_top with its defines; the bench drives every port itself, no partner model
`timescale 1ns/1ps
`default_nettype none
`include "ccsc_defs.svh"
module ccsc_tb_top;
    logic        core_clk       = 1'b0;
    logic        rst_n          = 1'b0;
    logic        ce             = 1'b1;
    logic [3:0]  address        = 4'h0;
    logic        read           = 1'b0;
    logic        write          = 1'b0;
    logic [3:0]  byteenable     = 4'h0;
    logic [31:0] writedata      = 32'h0;
    logic        fast_osc_tick  = 1'b0;
    logic        main_osc_tick  = 1'b0;
    logic        sub_osc_tick   = 1'b0;
    logic        low_osc_tick   = 1'b0;
    logic        stop_instr     = 1'b0;
    logic        stop_release   = 1'b0;
    logic        wdt_enable     = 1'b1;
    logic        wdt_standby_on = 1'b0;
    logic [7:0]  tc             = 8'h00;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        wdt_clk_en;
    logic        fast_osc_run;
    logic        main_osc_run;
    logic        sub_osc_run;
    logic        low_osc_run;
    logic        sub_pins_port_mode;
    logic        analog_i2c_ok;
    logic        stop_mode_active;
    logic [6:0]  lv;
    int          mismatches     = 0;
    int          comparisons    = 0;

    assign lv = {fast_osc_run, main_osc_run, sub_osc_run, low_osc_run,
                 sub_pins_port_mode, analog_i2c_ok, stop_mode_active};

    ccsc_top dut (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .ce                 (ce),
        .address            (address),
        .read               (read),
        .write              (write),
        .byteenable         (byteenable),
        .writedata          (writedata),
        .readdata           (readdata),
        .waitrequest        (waitrequest),
        .fast_osc_tick      (fast_osc_tick),
        .main_osc_tick      (main_osc_tick),
        .sub_osc_tick       (sub_osc_tick),
        .low_osc_tick       (low_osc_tick),
        .stop_instr         (stop_instr),
        .stop_release       (stop_release),
        .wdt_enable         (wdt_enable),
        .wdt_standby_on     (wdt_standby_on),
        .cpu_clk_en         (cpu_clk_en),
        .periph_clk_en      (periph_clk_en),
        .wdt_clk_en         (wdt_clk_en),
        .fast_osc_run       (fast_osc_run),
        .main_osc_run       (main_osc_run),
        .sub_osc_run        (sub_osc_run),
        .low_osc_run        (low_osc_run),
        .sub_pins_port_mode (sub_pins_port_mode),
        .analog_i2c_ok      (analog_i2c_ok),
        .stop_mode_active   (stop_mode_active)
    );

    always #2.5 core_clk = ~core_clk;

    // oscillator edges: fast every cycle, main every 2, sub every 4, slow every 8
    always @(posedge core_clk) begin
        tc <= tc + 8'h01;
        fast_osc_tick <= 1'b1;
        main_osc_tick <= (tc[0] == 1'b0);
        sub_osc_tick <= (tc[1:0] == 2'b00);
        low_osc_tick <= (tc[2:0] == 3'b000);
    end

    task automatic close_out;
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= 4'h1;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        chk(x & mask, exp);
    endtask

    // cycles between two cpu enable pulses; periph enable must match each cycle
    task automatic period(input int exp);
        int n;
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (periph_clk_en !== cpu_clk_en) begin
                chk({31'h0, periph_clk_en}, {31'h0, cpu_clk_en});
            end
        end while (cpu_clk_en !== 1'b1 && n < 200);
        chk(32'(n), 32'(exp));
    endtask

    task automatic pulse_stop(input logic rel);
        @(posedge core_clk);
        if (rel) stop_release <= 1'b1;
        else stop_instr <= 1'b1;
        @(posedge core_clk);
        stop_release <= 1'b0;
        stop_instr <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({25'h0, lv}, {25'h0, 7'b1001110});
        rdchk(`CCSC_ADDR_MODE, 32'h00, 32'hffffffff);
        rdchk(`CCSC_ADDR_SYS, 32'h09, 32'hffffffff);
        rdchk(`CCSC_ADDR_RUN, 32'hc0, 32'hffffffff);
        rdchk(4'hc, 32'h0, 32'hffffffff);
        for (int d = 0; d < 8; d++) begin
            wr(`CCSC_ADDR_SYS, 8'(d));
            repeat (70) @(posedge core_clk);
            rdchk(`CCSC_ADDR_SYS, 32'h08 | 32'(d), 32'hffffffff);
            period((d > 5) ? 32 : (1 << d));
        end
        while (low_osc_tick !== 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        chk({31'h0, wdt_clk_en}, 32'h1);
        // bits 5 and 3 are reserved and must not stick; only the first write counts
        wr(`CCSC_ADDR_MODE, 8'h5e);
        rdchk(`CCSC_ADDR_MODE, 32'h56, 32'hffffffff);
        wr(`CCSC_ADDR_MODE, 8'hff);
        rdchk(`CCSC_ADDR_MODE, 32'h56, 32'hffffffff);
        wr(`CCSC_ADDR_RUN, 8'h00);
        repeat (2) @(posedge core_clk);
        chk({25'h0, lv}, {25'h0, 7'b1111010});
        wr(`CCSC_ADDR_SYS, 8'h10);
        repeat (60) @(posedge core_clk);
        rdchk(`CCSC_ADDR_SYS, 32'h38, 32'hffffffff);
        period(2);
        wr(`CCSC_ADDR_SYS, 8'h40);
        repeat (60) @(posedge core_clk);
        rdchk(`CCSC_ADDR_SYS, 32'hc0, 32'hc0);
        period(8);
        chk({31'h0, analog_i2c_ok}, 32'h0);
        wr(`CCSC_ADDR_RUN, 8'h01);
        repeat (2) @(posedge core_clk);
        chk({25'h0, lv}, {25'h0, 7'b0111000});
        period(8);
        wr(`CCSC_ADDR_RUN, 8'h00);
        repeat (2) @(posedge core_clk);
        chk({31'h0, fast_osc_run}, 32'h1);
        rdchk(`CCSC_ADDR_RUN, 32'h00, 32'h02);
        repeat (`CCSC_SETTLE_CYC + 20) @(posedge core_clk);
        rdchk(`CCSC_ADDR_RUN, 32'h02, 32'h02);
        wr(`CCSC_ADDR_SYS, 8'h01);
        repeat (60) @(posedge core_clk);
        rdchk(`CCSC_ADDR_SYS, 32'h09, 32'hffffffff);
        period(2);
        chk({31'h0, analog_i2c_ok}, 32'h1);
        wr(`CCSC_ADDR_RUN, 8'h40);
        repeat (2) @(posedge core_clk);
        chk({31'h0, sub_osc_run}, 32'h0);
        wr(`CCSC_ADDR_RUN, 8'h00);
        repeat (2) @(posedge core_clk);
        // no stabilization register in this block; peripherals are idle here
        pulse_stop(1'b0);
        chk({25'h0, lv}, {25'h0, 7'b0010011});
        pulse_stop(1'b1);
        chk({30'h0, low_osc_run, stop_mode_active}, 32'h2);
        // software cannot stop the slow osc while the watchdog runs
        // cpu is on the fast osc, so only main and sub stop bits may be set
        wr(`CCSC_ADDR_RUN, 8'hc2);
        repeat (2) @(posedge core_clk);
        chk({31'h0, low_osc_run}, 32'h1);
        // a stop request while the clock enable is low must leave no trace
        ce <= 1'b0;
        stop_instr <= 1'b1;
        @(posedge core_clk);
        stop_instr <= 1'b0;
        @(posedge core_clk);
        ce <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({31'h0, stop_mode_active}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire

// [ccsc_tick_div.sv]
// power-of-two divider of an oscillator tick stream into one-cycle pulses
// assumes tick is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module ccsc_tick_div (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic [2:0] shift,
    output logic            pulse
);
    ccsc_pkg::ccsc_div_st_t st;
    ccsc_pkg::ccsc_div_st_t next_st;
    logic [4:0]             mask;

    always_comb begin
        mask = 5'((5'h1 << shift) - 5'h1);
        next_st = st;
        next_st.pulse = 1'b0;
        if (restart) begin
            next_st.cnt = 5'h0;
        end else if (tick) begin
            if (st.cnt >= mask) begin
                next_st.cnt = 5'h0;
                next_st.pulse = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 5'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pulse = st.pulse;
endmodule
`default_nettype wire

// [ccsc_top.sv]
// cpu/peripheral clock source control: source select, dividers, oscillator run control
// assumes oscillator ticks and stop/wake events are synchronous one-cycle pulses
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccsc_defs.svh"
module ccsc_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        fast_osc_tick,
    input  wire logic        main_osc_tick,
    input  wire logic        sub_osc_tick,
    input  wire logic        low_osc_tick,
    input  wire logic        stop_instr,
    input  wire logic        stop_release,
    input  wire logic        wdt_enable,
    input  wire logic        wdt_standby_on,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             wdt_clk_en,
    output logic             fast_osc_run,
    output logic             main_osc_run,
    output logic             sub_osc_run,
    output logic             low_osc_run,
    output logic             sub_pins_port_mode,
    output logic             analog_i2c_ok,
    output logic             stop_mode_active
);
    ccsc_pkg::ccsc_top_st_t st;
    ccsc_pkg::ccsc_top_st_t next_st;
    ccsc_pkg::ccsc_src_t    want;
    logic [7:0]             mode_q;
    logic [7:0]             sys_q;
    logic [7:0]             run_q;
    logic                   wr_mode;
    logic                   wr_sys;
    logic                   wr_run;
    logic [7:0]             wdata;
    logic [2:0]             ticks;
    logic [2:0]             pulses;
    logic [2:0]             shifts [3];
    logic                   cur_pulse;
    logic                   cur_live;
    logic                   want_live;

    // reserved codes clamp to the slowest legal ratio
    function automatic logic [2:0] ccsc_shift(input logic [2:0] code);
        ccsc_shift = (code > `CCSC_DIV_MAX) ? `CCSC_DIV_MAX : code;
    endfunction

    ccsc_avmm_slave u_bus (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .address     (address),
        .read        (read),
        .write       (write),
        .byteenable  (byteenable),
        .writedata   (writedata),
        .mode_q      (mode_q),
        .sys_q       (sys_q),
        .run_q       (run_q),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .wr_mode     (wr_mode),
        .wr_sys      (wr_sys),
        .wr_run      (wr_run),
        .wdata       (wdata)
    );

    // only a running oscillator delivers ticks
    assign ticks = {sub_osc_tick && st.sub_run, main_osc_tick && st.main_run,
                    fast_osc_tick && st.fast_run};
    assign shifts[0] = ccsc_shift(st.div);
    assign shifts[1] = ccsc_shift(st.div);
    assign shifts[2] = `CCSC_SUB_SHIFT;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            ccsc_tick_div u_div (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .ce       (ce),
                .tick     (ticks[gi]),
                .restart  (st.restart),
                .shift    (shifts[gi]),
                .pulse    (pulses[gi])
            );
        end
    endgenerate

    assign mode_q = st.mode;
    assign sys_q = {st.src == ccsc_pkg::CCSC_SRC_SUB, st.subclock_cpu_select,
                    st.src == ccsc_pkg::CCSC_SRC_MAIN, st.mcm, 1'b1, st.div};
    assign run_q = {st.mstop, st.sub_crystal_stop, 4'h0, st.settled, st.internal_fast_osc_stop};

    always_comb begin
        next_st = st;
        next_st.restart = 1'b0;
        // single write after reset, later attempts dropped
        if (wr_mode && !st.mode_done) begin
            next_st.mode = wdata & `CCSC_MODE_WMASK;
            next_st.mode_done = 1'b1;
        end else if (wr_mode) begin
            next_st.mode_done = 1'b1;
        end
        if (wr_sys) begin
            next_st.subclock_cpu_select = wdata[`CCSC_SYS_CSS];
            next_st.mcm = wdata[`CCSC_SYS_MCM];
            next_st.div = wdata[2:0];
        end
        if (wr_run) begin
            next_st.mstop = wdata[`CCSC_RUN_MSTOP];
            next_st.sub_crystal_stop = wdata[`CCSC_RUN_SUB_CRYSTAL_STOP];
            next_st.internal_fast_osc_stop = wdata[`CCSC_RUN_INTERNAL_FAST_OSC_STOP];
        end
        // wake beats a stop request landing in the same cycle
        if (stop_release) begin
            next_st.stop = 1'b0;
        end else if (stop_instr) begin
            next_st.stop = 1'b1;
        end
        next_st.fast_run = !next_st.internal_fast_osc_stop && !next_st.stop;
        next_st.main_run = next_st.mode[`CCSC_MODE_MAINOSC] && !next_st.mstop && !next_st.stop;
        // stop mode does not touch the sub crystal
        next_st.sub_run = next_st.mode[`CCSC_MODE_SUBEN] && !next_st.sub_crystal_stop;
        next_st.port_mode = !next_st.mode[`CCSC_MODE_SUBEN];
        // slow osc only answers to watchdog option inputs and to stop mode
        next_st.low_run = wdt_enable && !(next_st.stop && !wdt_standby_on);
        next_st.wdt_clk_en = low_osc_tick && st.low_run;
        // settle flag: accuracy window after the fast osc comes back
        if (!st.fast_run) begin
            next_st.settle_cnt = 11'h000;
            next_st.settled = 1'b0;
        end else if (st.settle_cnt >= 11'(`CCSC_SETTLE_CYC - 1)) begin
            next_st.settled = 1'b1;
        end else begin
            next_st.settle_cnt = st.settle_cnt + 11'h001;
        end
        // switch only at the old source's pulse boundary, or when it is dead
        if (want != st.src && want_live && (cur_pulse || !cur_live)) begin
            next_st.src = want;
            next_st.restart = 1'b1;
        end
        next_st.cpu_clk_en = cur_pulse && !st.stop;
        next_st.periph_clk_en = cur_pulse && !st.stop;
        next_st.ana_ok = next_st.src != ccsc_pkg::CCSC_SRC_SUB;
    end

    always_comb begin
        if (st.subclock_cpu_select) begin
            want = ccsc_pkg::CCSC_SRC_SUB;
        end else if (st.mcm) begin
            want = ccsc_pkg::CCSC_SRC_MAIN;
        end else begin
            want = ccsc_pkg::CCSC_SRC_FAST;
        end
        case (st.src)
            ccsc_pkg::CCSC_SRC_FAST: begin
                cur_pulse = pulses[0];
                cur_live = st.fast_run;
            end
            ccsc_pkg::CCSC_SRC_MAIN: begin
                cur_pulse = pulses[1];
                cur_live = st.main_run;
            end
            ccsc_pkg::CCSC_SRC_SUB: begin
                cur_pulse = pulses[2];
                cur_live = st.sub_run;
            end
            default: begin
                cur_pulse = 1'b0;
                cur_live = 1'b0;
            end
        endcase
        case (want)
            ccsc_pkg::CCSC_SRC_FAST: want_live = st.fast_run;
            ccsc_pkg::CCSC_SRC_MAIN: want_live = st.main_run;
            ccsc_pkg::CCSC_SRC_SUB: want_live = st.sub_run;
            default: want_live = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= `CCSC_MODE_RESET;
            st.div <= 3'(`CCSC_SYS_RESET & 8'h07);
            st.mstop <= 1'b1;
            st.sub_crystal_stop <= 1'b1;
            st.src <= ccsc_pkg::CCSC_SRC_FAST;
            st.fast_run <= 1'b1;
            st.port_mode <= 1'b1;
            st.ana_ok <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign cpu_clk_en = st.cpu_clk_en;
    assign periph_clk_en = st.periph_clk_en;
    assign wdt_clk_en = st.wdt_clk_en;
    assign fast_osc_run = st.fast_run;
    assign main_osc_run = st.main_run;
    assign sub_osc_run = st.sub_run;
    assign low_osc_run = st.low_run;
    assign sub_pins_port_mode = st.port_mode;
    assign analog_i2c_ok = st.ana_ok;
    assign stop_mode_active = st.stop;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_fast_pulse;
        st.src == ccsc_pkg::CCSC_SRC_FAST && pulses[0] && !st.stop;
    endsequence
    sequence s_enable_out;
        ##1 cpu_clk_en && periph_clk_en;
    endsequence

    property p_fast_div;
        s_fast_pulse |-> s_enable_out;
    endproperty
    a_fast_div: assert property (p_fast_div) else $error("fast pulse lost");

    property p_stop_halts;
        $rose(stop_mode_active) |-> !fast_osc_run && !main_osc_run ##1 !cpu_clk_en;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("stop left fast osc on");

    // status must name the source whose pulse really reaches the cpu
    property p_status;
        (sys_q[`CCSC_SYS_CLS] ? pulses[2] : (sys_q[`CCSC_SYS_MCS] ? pulses[1] : pulses[0]))
            && !stop_mode_active |=> cpu_clk_en;
    endproperty
    a_status: assert property (p_status) else $error("status mismatch");

    property p_fast_stop_bit;
        wr_run && wdata[`CCSC_RUN_INTERNAL_FAST_OSC_STOP] |=> !fast_osc_run ##1 !pulses[0];
    endproperty
    a_fast_stop_bit: assert property (p_fast_stop_bit) else $error("fast osc kept running");

    property p_fast_restart;
        wr_run && !wdata[`CCSC_RUN_INTERNAL_FAST_OSC_STOP] && !stop_instr && !st.stop |=> fast_osc_run;
    endproperty
    a_fast_restart: assert property (p_fast_restart) else $error("fast osc not restarted");

    property p_sub_ctl;
        wr_run && st.mode[`CCSC_MODE_SUBEN] |=> sub_osc_run == !$past(wdata[`CCSC_RUN_SUB_CRYSTAL_STOP]);
    endproperty
    a_sub_ctl: assert property (p_sub_ctl) else $error("sub crystal control wrong");

    property p_sub_thru_stop;
        stop_mode_active && $past(sub_osc_run) && !$past(wr_run) |-> sub_osc_run;
    endproperty
    a_sub_thru_stop: assert property (p_sub_thru_stop) else $error("stop halted subclock");

    property p_mode_once;
        st.mode_done && wr_mode |=> $stable(mode_q);
    endproperty
    a_mode_once: assert property (p_mode_once) else $error("mode rewritten");

    property p_sub_half;
        st.src == ccsc_pkg::CCSC_SRC_SUB && st.subclock_cpu_select && pulses[2] && !st.stop |=> cpu_clk_en && !analog_i2c_ok;
    endproperty
    a_sub_half: assert property (p_sub_half) else $error("subclock pulse lost");

    property p_low_osc;
        wdt_enable && !stop_instr && !stop_mode_active |=> low_osc_run;
    endproperty
    a_low_osc: assert property (p_low_osc) else $error("slow osc stopped");

    property p_switch_edge;
        st.src != $past(st.src) |-> $past(cur_pulse) || !$past(cur_live);
    endproperty
    a_switch_edge: assert property (p_switch_edge) else $error("switch mid period");
endmodule
`default_nettype wire
